//--- design/dpl_pkg.sv
// Shared constants for the digital port and its result/codeword link
package dpl_pkg;
  localparam int SYS_CLK_KHZ = 40000;
  localparam int SYS_CLK_NS = 25;
  localparam int PORT_CLK_KHZ = 56250;
  localparam int STROBE_KHZ = 25000;
  localparam int CW_MAX_KHZ = 50000;
  localparam int REF_CLK_KHZ = 10000;
  localparam int EXT_CLK_NS = 200;
  // The system clock is slower than the port clock, so the port clock is scaled down
  localparam int PORT_HALF_CYC =
    (SYS_CLK_KHZ / (2 * PORT_CLK_KHZ) < 2) ? 2 : SYS_CLK_KHZ / (2 * PORT_CLK_KHZ);
  localparam int CTL_SLOT_CYC =
    (SYS_CLK_KHZ / CW_MAX_KHZ < 4) ? 4 : SYS_CLK_KHZ / CW_MAX_KHZ;
  localparam int EXT_HALF_CYC = EXT_CLK_NS / (2 * SYS_CLK_NS);
  localparam logic [3:0] PORT_HALF_M1 = 4'(PORT_HALF_CYC - 1);
  localparam logic [3:0] CTL_SLOT_M1 = 4'(CTL_SLOT_CYC - 1);
  localparam logic [3:0] EXT_HALF_M1 = 4'(EXT_HALF_CYC - 1);
  localparam logic [31:0] DECIM_RESET = 32'h0055D4A8;
  localparam int PORT_W = 32;
  localparam int BYTES = 4;
  // Result direction pin map
  localparam int VALID_BIT = 0;
  localparam int RES_LSB = 1;
  localparam int RES_W = 10;
  localparam int RSV_LSB = 11;
  localparam int RSV_W = 3;
  localparam int VALID_COPY_BIT = 14;
  localparam int STRB_BIT = 15;
  // Codeword input direction pin map
  localparam int CWI_LSB = 16;
  localparam int CWI_W = 10;
  localparam int CWI_VALID_BIT = 26;
  localparam int CWI_STRB_BIT = 27;
  // Controller register word addresses
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_TXCW = 4'h1;
  localparam logic [3:0] REG_STAT = 4'h2;
  localparam logic [3:0] REG_RXCW = 4'h3;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_EXT_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
endpackage : dpl_pkg

//--- design/dpl_link_if.sv
// Pin carrier between the port device and the central controller
`timescale 1ns/1ps
`default_nettype none
interface dpl_link_if;
  logic [31:0] dev_out;
  logic [3:0] dev_oe_b;
  logic [31:0] ctl_out;
  logic [3:0] ctl_oe_b;
  logic latch_clk;
  logic ext_sample_clk;
  logic ref_clk;
  logic [31:0] port_bits;

  // Wire level per byte: device wins, then controller, else weak low
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      if (!dev_oe_b[b]) begin
        port_bits[b*8 +: 8] = dev_out[b*8 +: 8];
      end else if (!ctl_oe_b[b]) begin
        port_bits[b*8 +: 8] = ctl_out[b*8 +: 8];
      end else begin
        port_bits[b*8 +: 8] = 8'h00;
      end
    end
  end

  modport dev (input port_bits, ext_sample_clk, ref_clk, output dev_out, dev_oe_b, latch_clk);
  modport ctl (input port_bits, latch_clk, ref_clk, output ctl_out, ctl_oe_b, ext_sample_clk);
endinterface : dpl_link_if
`default_nettype wire

//--- design/dpl_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module dpl_sync #(
  parameter int W = 1  // Bus width
) (
  input wire logic i_clk_sys,  // System clock
  input wire logic i_rst_b,  // Async reset, active low
  input wire logic [W-1:0] i_d,  // Raw pins
  output logic [W-1:0] o_q  // Filtered level
);
  logic [W-1:0] s1_q, s2_q, s3_q, f_q;

  // A bit moves only once stages two and three agree
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      f_q <= '0;
    end else begin
      s1_q <= i_d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q <= (s2_q & s3_q) | (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & f_q);
    end
  end

  assign o_q = f_q;
endmodule : dpl_sync
`default_nettype wire

//--- design/dpl_port_ctl.sv
// Central controller end: sends codewords and collects results
`timescale 1ns/1ps
`default_nettype none
module dpl_port_ctl
  import dpl_pkg::*;
(
  input wire logic i_clk_sys,  // System clock
  input wire logic i_rst_b,  // Async reset, active low
  dpl_link_if.ctl link,  // Port pins
  input wire logic [3:0] i_addr,  // Register word address
  input wire logic [31:0] i_wdata,  // Write data
  input wire logic i_wr,  // Write strobe
  input wire logic i_rd,  // Read strobe
  output logic [31:0] o_rdata  // Read data, cycle after read
);
  logic [16:0] pin_filt;
  logic ref_prev_q, strb_prev_q;
  logic ref_rise, slot_en, ext_done, rx_got, wr_txcw, rd_rxcw, rx_valid;
  logic [3:0] slot_cnt_q, ext_cnt_q;
  logic [1:0] ctrl_q;
  logic [CWI_W-1:0] tx_cw_q;
  logic [RES_W-1:0] rx_cw_q;
  logic tx_pend_q, rx_new_q, ext_q;
  logic [31:0] out_q, rd_mux, rdata_q;
  logic [3:0] oe_b_q;

  dpl_sync #(.W(17)) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_d({link.ref_clk, link.port_bits[15:0]}),
    .o_q(pin_filt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register port
  assign wr_txcw = i_wr & (i_addr == REG_TXCW);
  assign rd_rxcw = i_rd & (i_addr == REG_RXCW);
  assign rd_mux = (i_addr == REG_CTRL) ? {30'h0, ctrl_q} :
                  (i_addr == REG_TXCW) ? {22'h0, tx_cw_q} :
                  (i_addr == REG_STAT) ? {30'h0, rx_new_q, tx_pend_q} :
                  (i_addr == REG_RXCW) ? {22'h0, rx_cw_q} : 32'h0;

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_q <= CTRL_RESET;
      tx_cw_q <= '0;
      rdata_q <= 32'h0;
    end else begin
      if (i_wr && i_addr == REG_CTRL) begin
        ctrl_q <= i_wdata[1:0];
      end
      if (wr_txcw) begin
        tx_cw_q <= i_wdata[CWI_W-1:0];
      end
      rdata_q <= i_rd ? rd_mux : 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slot grid, restarted by the shared reference
  assign ref_rise = pin_filt[16] & ~ref_prev_q;
  assign slot_en = (slot_cnt_q == CTL_SLOT_M1) & ~ref_rise;
  assign ext_done = (ext_cnt_q == EXT_HALF_M1);

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ref_prev_q <= 1'b0;
      slot_cnt_q <= 4'h0;
      ext_cnt_q <= 4'h0;
      ext_q <= 1'b0;
    end else begin
      ref_prev_q <= pin_filt[16];
      // A reference edge counts as the first slot cycle: with equal periods a
      // reload of one keeps the slot that would otherwise meet each edge
      slot_cnt_q <= ref_rise ? 4'h1 : (slot_en ? 4'h0 : slot_cnt_q + 4'h1);
      ext_cnt_q <= ext_done ? 4'h0 : ext_cnt_q + 4'h1;
      if (!ctrl_q[CTRL_EXT_BIT]) begin
        ext_q <= 1'b0;
      end else if (ext_done) begin
        ext_q <= ~ext_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Codeword transmit: valid rides only with a pending codeword
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      out_q <= 32'h0;
      oe_b_q <= 4'hF;
      tx_pend_q <= 1'b0;
    end else begin
      oe_b_q <= {~ctrl_q[CTRL_EN_BIT], ~ctrl_q[CTRL_EN_BIT], 2'h3};
      tx_pend_q <= wr_txcw | (tx_pend_q & ~(slot_en & ctrl_q[CTRL_EN_BIT]));
      if (slot_en && ctrl_q[CTRL_EN_BIT]) begin
        out_q[CWI_STRB_BIT] <= ~out_q[CWI_STRB_BIT];
        out_q[CWI_VALID_BIT] <= tx_pend_q;
        out_q[CWI_LSB +: CWI_W] <= tx_cw_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result receive on each strobe change; the latch clock pin is not used
  assign rx_valid = pin_filt[VALID_BIT] & pin_filt[VALID_COPY_BIT];
  assign rx_got = (pin_filt[STRB_BIT] ^ strb_prev_q) & rx_valid;

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      strb_prev_q <= 1'b0;
      rx_cw_q <= '0;
      rx_new_q <= 1'b0;
    end else begin
      strb_prev_q <= pin_filt[STRB_BIT];
      if (rx_got) begin
        rx_cw_q <= pin_filt[RES_LSB +: RES_W];
      end
      rx_new_q <= rx_got | (rx_new_q & ~rd_rxcw);
    end
  end

  assign link.ctl_out = out_q;
  assign link.ctl_oe_b = oe_b_q;
  assign link.ext_sample_clk = ext_q;
  assign o_rdata = rdata_q;
endmodule : dpl_port_ctl
`default_nettype wire

//--- design/dpl_port_dev.sv
// Device end: 32-bit byte-wise digital port with result and codeword link
//
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Operation
// - Thirty-two port bits, drive set per byte
// - All outputs change on port clock falling edge
// - Port clock driven out on latch clock pin
// - Input sampling from internal or external clock
// - Count clock edges, latch inputs at decimation
// - Decimation value after reset is 5625000
// - Far side may drive the external sample clock
// - Valid flag on bits zero and fourteen
// - Ten result bits on bits ten to one
// - Bits thirteen to eleven reserved, ignored by receiver
// - Alignment toggle driven on bit fifteen
// - Mapping needs result mode and output drive
// - Controller ignores latch clock for link
// - Controller sends codewords, device acts on each while bytes two and three are inputs
// - Link carries codewords in and results out
// - Both ends align to shared reference clock
// - Strobe toggles at fixed rate, sets grid
// - Valid high exactly when codeword present
// - Controller codeword rate is system clock divided by four
////////////////////////////////////////////////////////////////////////////////
module dpl_port_dev
  import dpl_pkg::*;
#(
  parameter logic [31:0] DECIM_DEFAULT = DECIM_RESET  // Decimation after reset
) (
  input wire logic i_clk_sys,  // System clock
  input wire logic i_rst_b,  // Async reset, active low
  dpl_link_if.dev link,  // Port pins
  input wire logic [3:0] i_drive,  // Per byte: 1 drives the byte
  input wire logic i_mode_result,  // Result link pin mapping
  input wire logic i_ext_sel,  // Sample inputs on external clock
  input wire logic i_decim_wr,  // Load decimation value
  input wire logic [31:0] i_decim_val,  // New decimation value
  input wire logic [31:0] i_out_bits,  // General output data
  input wire logic [RES_W-1:0] i_result,  // Quantized readout results
  input wire logic i_result_valid,  // Result pulse
  output logic [31:0] o_in_bits,  // Latched input bits
  output logic o_in_sample,  // Pulse when inputs latched
  output logic [CWI_W-1:0] o_cw,  // Received codeword
  output logic o_cw_valid,  // Pulse per received codeword
  output logic [31:0] o_decim  // Current decimation value
);
  logic [33:0] pin_filt;
  logic [31:0] port_in;
  logic ref_prev_q, ext_prev_q, cw_prev_q;
  logic ref_rise, ext_rise, half_done, fall_en, rise_en;
  logic [3:0] div_cnt_q;
  logic port_clk_q;
  logic [31:0] out_q, next_out;
  logic [3:0] oe_b_q;
  logic pend_q;
  logic [RES_W-1:0] hold_q;
  logic [31:0] decim_q, dec_cnt_q, dec_last;
  logic in_edge, dec_hit;
  logic [31:0] in_q;
  logic in_smp_q;
  logic cw_change, cw_take, cw_bytes_in;
  logic [CWI_W-1:0] cw_q;
  logic cw_vld_q;

  dpl_sync #(.W(34)) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_d({link.ref_clk, link.ext_sample_clk, link.port_bits}),
    .o_q(pin_filt)
  );
  assign port_in = pin_filt[31:0];

  // Rising edge of a filtered pin against its value one cycle back
  function automatic logic rise_seen(input logic now_lvl, input logic prev_lvl);
    return now_lvl & ~prev_lvl;
  endfunction : rise_seen

  ////////////////////////////////////////////////////////////////////////////
  // Port clock divider, re-phased by the shared reference
  // The port clock is a scaled stand-in: the system clock cannot reach the true rate
  assign ref_rise = rise_seen(pin_filt[33], ref_prev_q);
  assign ext_rise = rise_seen(pin_filt[32], ext_prev_q);
  assign half_done = (div_cnt_q == PORT_HALF_M1);
  assign fall_en = half_done & port_clk_q & ~ref_rise;
  assign rise_en = ~port_clk_q & (half_done | ref_rise);

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ref_prev_q <= 1'b0;
      ext_prev_q <= 1'b0;
      div_cnt_q <= 4'h0;
      port_clk_q <= 1'b0;
    end else begin
      ref_prev_q <= pin_filt[33];
      ext_prev_q <= pin_filt[32];
      if (ref_rise) begin
        div_cnt_q <= 4'h0;
        port_clk_q <= 1'b1;
      end else if (half_done) begin
        div_cnt_q <= 4'h0;
        port_clk_q <= ~port_clk_q;
      end else begin
        div_cnt_q <= div_cnt_q + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output frame; reserved bits held low so nothing leaks onto them
  always_comb begin
    next_out = i_out_bits;
    if (i_mode_result) begin
      next_out[VALID_BIT] = pend_q;
      next_out[VALID_COPY_BIT] = pend_q;
      next_out[RES_LSB +: RES_W] = hold_q;
      next_out[RSV_LSB +: RSV_W] = 3'h0;
      next_out[STRB_BIT] = ~out_q[STRB_BIT];
    end
  end

  // A result arriving on a falling edge waits for the next slot
  // A new result wins over the slot clear; a second result while one is pending replaces hold_q
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pend_q <= 1'b0;
      hold_q <= '0;
    end else begin
      pend_q <= i_result_valid | (pend_q & ~(fall_en & i_mode_result));
      if (i_result_valid) begin
        hold_q <= i_result;
      end
    end
  end

  // Data and drive enables move together, only on the falling edge
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      out_q <= 32'h0;
      oe_b_q <= 4'hF;
    end else if (fall_en) begin
      out_q <= next_out;
      oe_b_q <= ~i_drive;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input decimation; a value of zero behaves as one
  // A count left above a lowered value latches at the next edge
  assign in_edge = i_ext_sel ? ext_rise : rise_en;
  assign dec_last = (decim_q == 32'h0) ? 32'h0 : decim_q - 32'h1;
  assign dec_hit = in_edge & (dec_cnt_q >= dec_last);

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      decim_q <= DECIM_DEFAULT;
      dec_cnt_q <= 32'h0;
      in_q <= 32'h0;
      in_smp_q <= 1'b0;
    end else begin
      if (i_decim_wr) begin
        decim_q <= i_decim_val;
      end
      if (dec_hit) begin
        dec_cnt_q <= 32'h0;
        in_q <= port_in;
      end else if (in_edge) begin
        dec_cnt_q <= dec_cnt_q + 32'h1;
      end
      in_smp_q <= dec_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Codeword receive on each strobe change; bytes must be inputs.
  // Skew between strobe and data beyond one filter stage is not tolerated.
  // Judged on the enables now on the pins, not on the requested drive
  assign cw_bytes_in = oe_b_q[2] & oe_b_q[3];
  assign cw_change = port_in[CWI_STRB_BIT] ^ cw_prev_q;
  assign cw_take = cw_change & port_in[CWI_VALID_BIT] & cw_bytes_in;

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cw_prev_q <= 1'b0;
      cw_q <= '0;
      cw_vld_q <= 1'b0;
    end else begin
      cw_prev_q <= port_in[CWI_STRB_BIT];
      cw_vld_q <= cw_take;
      if (cw_take) begin
        cw_q <= port_in[CWI_LSB +: CWI_W];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign link.dev_out = out_q;
  assign link.dev_oe_b = oe_b_q;
  assign link.latch_clk = port_clk_q;
  assign o_in_bits = in_q;
  assign o_in_sample = in_smp_q;
  assign o_cw = cw_q;
  assign o_cw_valid = cw_vld_q;
  assign o_decim = decim_q;
endmodule : dpl_port_dev
`default_nettype wire

//--- tb/dpl_link_monitor.sv
// Concurrent checks on the pins between the port device and the controller
`timescale 1ns/1ps
`default_nettype none
module dpl_link_monitor (
  input wire logic i_clk_sys,  // System clock
  input wire logic i_rst_b,  // Async reset, active low
  input wire logic i_mode_result,  // Result mapping selected
  input wire logic [31:0] dev_out,  // Device pin data
  input wire logic [3:0] dev_oe_b,  // Device byte enables, low drives
  input wire logic [31:0] ctl_out,  // Controller pin data
  input wire logic latch_clk,  // Output latch clock pin
  input wire logic ext_sample_clk  // External sample clock
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_b);
  property p_out_on_fall;
    $changed(dev_out) |-> $fell(latch_clk);
  endproperty
  a_out_on_fall: assert property (p_out_on_fall) else $error("Output moved off fall");
  property p_oe_on_fall;
    $changed(dev_oe_b) |-> $fell(latch_clk);
  endproperty
  a_oe_on_fall: assert property (p_oe_on_fall) else $error("Drive moved off fall");
  property p_latch_half;
    $rose(latch_clk) |=> latch_clk ##[1:3] !latch_clk;
  endproperty
  a_latch_half: assert property (p_latch_half) else $error("Latch clock high too long");
  // Mapping is only judged once mode and drive have settled over two port periods
  property p_valid_copy;
    (i_mode_result && dev_oe_b[1:0] == 2'h0) [*8] |-> dev_out[0] == dev_out[14];
  endproperty
  a_valid_copy: assert property (p_valid_copy) else $error("Valid copy differs");
  property p_rsv_low;
    (i_mode_result && dev_oe_b[1] == 1'b0) [*8] |-> dev_out[13:11] == 3'h0;
  endproperty
  a_rsv_low: assert property (p_rsv_low) else $error("Reserved bits set");
  property p_strobe_toggle;
    ((i_mode_result && !dev_oe_b[1]) [*8] ##0 $fell(latch_clk)) |-> $changed(dev_out[15]);
  endproperty
  a_strobe_toggle: assert property (p_strobe_toggle) else $error("Strobe missed a fall");
  property p_cw_with_strobe;
    $changed(ctl_out[26:16]) |-> $changed(ctl_out[27]);
  endproperty
  a_cw_with_strobe: assert property (p_cw_with_strobe) else $error("Codeword off grid");
  property p_slot_gap;
    $changed(ctl_out[27]) |=> $stable(ctl_out[27]) [*3];
  endproperty
  a_slot_gap: assert property (p_slot_gap) else $error("Codeword slots too close");
  property p_ext_half;
    $rose(ext_sample_clk) |=> ext_sample_clk [*3] ##1 !ext_sample_clk;
  endproperty
  a_ext_half: assert property (p_ext_half) else $error("Sample clock half period");
endmodule : dpl_link_monitor
`default_nettype wire

//--- tb/dpl_result_link_test.sv
// Self-checking bench joining the device and controller ends of the port link
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module dpl_result_link_test;
  import dpl_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_rst_b, i_mode_result, i_ext_sel, i_decim_wr, i_result_valid, i_wr, i_rd, o_in_sample;
  logic o_cw_valid;
  logic [3:0] i_drive, i_addr;
  logic [9:0] i_result, o_cw;
  logic [31:0] i_decim_val, i_out_bits, o_in_bits, o_decim, i_wdata, o_rdata;
  logic [9:0] exp_res[$];
  logic [9:0] exp_cw[$];
  int n_mismatch = 0;
  int tests_run = 0;
  dpl_link_if link ();
  dpl_port_dev u_dpl_port_dev (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .link(link),
    .i_drive(i_drive), .i_mode_result(i_mode_result), .i_ext_sel(i_ext_sel),
    .i_decim_wr(i_decim_wr), .i_decim_val(i_decim_val), .i_out_bits(i_out_bits),
    .i_result(i_result), .i_result_valid(i_result_valid), .o_in_bits(o_in_bits),
    .o_in_sample(o_in_sample), .o_cw(o_cw), .o_cw_valid(o_cw_valid), .o_decim(o_decim));
  dpl_port_ctl u_dpl_port_ctl (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .link(link),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata));
  dpl_link_monitor u_dpl_link_monitor (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
    .i_mode_result(i_mode_result), .dev_out(link.dev_out), .dev_oe_b(link.dev_oe_b),
    .ctl_out(link.ctl_out), .latch_clk(link.latch_clk), .ext_sample_clk(link.ext_sample_clk));
  initial begin
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end
  // Shared 10 MHz reference, edges kept off the rising system clock edges and on the falling ones
  initial begin
    link.ref_clk = 1'b0;
    forever #50 link.ref_clk = ~link.ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run
  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask : bus_wr
  task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : bus_rd
  task automatic decim_run(input logic ext, input logic [31:0] dv, input int exp_t);
    int t;
    @(posedge i_clk_sys);
    i_ext_sel <= ext;
    i_decim_val <= dv;
    i_decim_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_decim_wr <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      t = 0;
      do begin
        @(negedge i_clk_sys);
        t++;
      end while (o_in_sample !== 1'b1 && t < 300);
    end
    `CHK(o_decim, dv)
    `CHK(t, exp_t)
    `CHK(o_in_bits[15:0], i_out_bits[15:0])
  endtask : decim_run
  task automatic send_result(input logic [9:0] r);
    logic [31:0] d;
    logic [9:0] e;
    exp_res.push_back(r);
    @(posedge i_clk_sys);
    i_result <= r;
    i_result_valid <= 1'b1;
    @(posedge i_clk_sys);
    i_result_valid <= 1'b0;
    d = 32'h0;
    for (int k = 0; k < 40 && d[1] !== 1'b1; k++) bus_rd(REG_STAT, d);
    `CHK(d[1], 1'b1)
    bus_rd(REG_RXCW, d);
    e = exp_res.pop_front();
    `CHK(d[9:0], e)
  endtask : send_result
  task automatic send_cw(input logic [9:0] c);
    exp_cw.push_back(c);
    bus_wr(REG_TXCW, {22'h0, c});
    for (int k = 0; k < 40 && exp_cw.size() > 0; k++) @(posedge i_clk_sys);
  endtask : send_cw
  // Every received codeword must have been sent, in order
  logic [9:0] cw_exp;
  always @(negedge i_clk_sys) begin
    if (i_rst_b && o_cw_valid === 1'b1) begin
      if (exp_cw.size() == 0) begin
        `CHK(1'b1, 1'b0)
      end else begin
        cw_exp = exp_cw.pop_front();
        `CHK(o_cw, cw_exp)
      end
    end
  end
  initial begin
    #(40000 * SYS_CLK_NS);
    n_mismatch++;
    complete_run;
  end
  initial begin
    logic [31:0] d;
    void'($urandom(66));
    {i_rst_b, i_mode_result, i_ext_sel, i_decim_wr, i_result_valid, i_wr, i_rd} = 7'h00;
    {i_addr, i_result, i_decim_val, i_wdata} = '0;
    i_drive = 4'h3;
    i_out_bits = $urandom() & 32'h03FFFFFF;
    repeat (8) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    `CHK(o_decim, 32'h0055D4A8)
    // After the reset value, decimation values never fall, so the running count never overshoots
    decim_run(1'b0, 32'h3, 12);
    bus_wr(REG_CTRL, 32'h3);
    decim_run(1'b1, 32'h3, 24);
    decim_run(1'b0, 32'h5, 20);
    bus_rd(4'hF, d);
    `CHK(d, 32'h0)
    @(posedge i_clk_sys);
    i_mode_result <= 1'b1;
    // The first frame after reset can look like a result; clear it first
    bus_rd(REG_RXCW, d);
    bus_rd(REG_STAT, d);
    `CHK(d[1], 1'b0)
    bus_rd(REG_CTRL, d);
    `CHK(d, 32'h3)
    repeat (6) send_result(10'($urandom()));
    repeat (6) send_cw(10'($urandom()));
    @(posedge i_clk_sys);
    i_drive <= 4'hF;
    repeat (12) @(posedge i_clk_sys);
    bus_wr(REG_TXCW, 32'h155);
    repeat (40) @(posedge i_clk_sys);
    i_drive <= 4'h3;
    // Let the device release the bytes and the pin filter settle
    repeat (12) @(posedge i_clk_sys);
    send_cw(10'h2AA);
    `CHK(exp_cw.size(), 0)
    complete_run;
  end
endmodule : dpl_result_link_test
`default_nettype wire
